// ---- logic/gpm_pkg.sv ----
// constants, types and register map for the gate period measure counter
// assumes a single 10 MHz clock and a plain strobe register port
package gpm_pkg;

   localparam int COUNT_W = 32;
   localparam int ADDR_W = 8;
   localparam int CFG_W = 9;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_SAVE = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_PULSE_N = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_PULSE_CTRL = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h14;

   localparam int CTRL_ARM_BIT = 0;
   localparam int CTRL_DISARM_BIT = 1;
   localparam int CTRL_CFG_LSB = 4;
   localparam int ST_ARMED_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_OVF_BIT = 2;
   localparam int ST_PG_BUSY_BIT = 3;
   localparam int PG_START_BIT = 0;
   localparam int PG_SRC_LSB = 1;

   localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h0000_0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h0000_0001;

   typedef enum logic [1:0] {
      MODE_PW = 2'h0,
      MODE_PERIOD = 2'h1,
      MODE_SEMI = 2'h2
   } gpm_mode_t;

   // gray along idle -> wait -> count -> done
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_WAIT = 2'h1,
      ST_COUNT = 2'h3,
      ST_DONE = 2'h2
   } gpm_state_t;

   typedef struct packed {
      logic [1:0] gate_sel;
      logic [1:0] src_sel;
      logic src_fall;
      logic gate_low;
      logic buffered;
      gpm_mode_t mode;
   } gpm_cfg_t;

   localparam gpm_cfg_t CFG_RESET = 9'h000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [COUNT_W-1:0] wdata;
      logic wr;
      logic rd;
   } gpm_bus_req_t;

endpackage

// ---- logic/gpm_counter.sv ----
// gate period measure counter: pulse width, period and semi-period capture
// plus a one-shot pulse generator for reciprocal frequency measurement
// assumes all pins synchronous to ref_clk and a non-waiting strobe bus
//
// Contract
// - buffered pulse width latches the count at every trailing gate edge
// - each buffered latched value goes out on the stream in order, except that a push into a stalled full stage overwrites it and sets overflow
// - period runs rising-to-rising or falling-to-falling as configured
// - count rising or falling source edges between the bounding gate edges
// - single period latches at second active edge then holds until read
// - buffered period latches each period end and keeps counting
// - buffered period starts at first active edge, no partial value
// - nothing is measured or latched before arming
// - buffered period and semi-period return zero with no source edge
// - semi-period interval is between any two consecutive gate edges
// - buffered semi-period latches on every gate edge
// - buffered semi-period starts at first gate edge, no partial value
// - single semi-period behaves as single pulse width
// - source selects fast timebase, slow timebase or external terminals
// - gate may come from an external function terminal
// - counter zero makes one pulse lasting n of its source periods
// - counter zero output can drive the measuring counter gate
// - single pulse width counts while active, latches, then ignores edges
// - pulse width measures high or low pulses as configured
// - the count is 32 bits wide
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module gpm_counter
   import gpm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire gpm_bus_req_t bus_req,
   output logic [COUNT_W-1:0] rd_data,
   input wire logic fast_internal_timebase,
   input wire logic slow_timebase,
   input wire logic [3:0] external_function_terminal,
   output logic [COUNT_W-1:0] stream_data,
   output logic stream_valid,
   input wire logic stream_ready,
   output logic counter0_out
);

   ////////////////////////////////////////////////////////////////////////////
   // registers

   gpm_cfg_t cfg_r;
   gpm_state_t state_r;
   gpm_state_t state_nxt;
   logic [COUNT_W-1:0] count_r;
   logic [COUNT_W-1:0] count_nxt;
   logic [COUNT_W-1:0] save_r;
   logic [COUNT_W-1:0] rd_data_r;
   logic [COUNT_W-1:0] stream_data_r;
   logic stream_valid_r;
   logic ovf_r;
   logic src_prev_r;
   logic gate_prev_r;
   logic [COUNT_W-1:0] pg_n_r;
   logic [COUNT_W-1:0] pg_cnt_r;
   logic [1:0] pg_src_sel_r;
   logic pg_busy_r;
   logic pulse_out_r;
   logic pg_prev_r;
   logic latch;

   ////////////////////////////////////////////////////////////////////////////
   // register decode

   wire wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);
   wire wr_status = bus_req.wr && (bus_req.addr == ADDR_STATUS);
   wire wr_pulse_n = bus_req.wr && (bus_req.addr == ADDR_PULSE_N);
   wire wr_pulse_ctrl = bus_req.wr && (bus_req.addr == ADDR_PULSE_CTRL);
   wire save_rd = bus_req.rd && (bus_req.addr == ADDR_SAVE);
   wire arm_wr = wr_ctrl && bus_req.wdata[CTRL_ARM_BIT];
   wire disarm_wr = wr_ctrl && bus_req.wdata[CTRL_DISARM_BIT];
   wire ctl_wr = arm_wr || disarm_wr;
   wire gpm_cfg_t cfg_wdata = gpm_cfg_t'(bus_req.wdata[CTRL_CFG_LSB +: CFG_W]);
   wire ovf_clr = wr_status && bus_req.wdata[ST_OVF_BIT];
   wire pg_start = wr_pulse_ctrl && bus_req.wdata[PG_START_BIT] && (pg_n_r != COUNT_ZERO);

   wire [COUNT_W-1:0] status_word;
   assign status_word = {{(COUNT_W-4){1'b0}}, pg_busy_r, ovf_r, state_r == ST_DONE, state_r != ST_IDLE};

   wire [COUNT_W-1:0] rd_mux;
   assign rd_mux = (bus_req.addr == ADDR_CTRL) ? {{(COUNT_W-CFG_W-CTRL_CFG_LSB){1'b0}}, cfg_r, 4'h0} :
                   (bus_req.addr == ADDR_STATUS) ? status_word :
                   (bus_req.addr == ADDR_SAVE) ? save_r :
                   (bus_req.addr == ADDR_PULSE_N) ? pg_n_r :
                   (bus_req.addr == ADDR_PULSE_CTRL) ? {{(COUNT_W-3){1'b0}}, pg_src_sel_r, pg_busy_r} :
                   (bus_req.addr == ADDR_COUNT) ? count_r : COUNT_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // input selection and edge detection

   wire [3:0] src_cand;
   wire [3:0] gate_cand;
   assign src_cand = {external_function_terminal[1], external_function_terminal[0],
                      slow_timebase, fast_internal_timebase};
   assign gate_cand = {pulse_out_r, external_function_terminal[0],
                       external_function_terminal[3], external_function_terminal[2]};

   wire src_now = src_cand[cfg_r.src_sel];
   wire gate_now = gate_cand[cfg_r.gate_sel];
   // a new pick on the arming write must not look like a gate edge
   wire gate_seed = wr_ctrl ? gate_cand[cfg_wdata.gate_sel] : gate_now;
   wire src_seed = wr_ctrl ? src_cand[cfg_wdata.src_sel] : src_now;
   wire src_hit = cfg_r.src_fall ? (src_prev_r && !src_now) : (!src_prev_r && src_now);
   wire gate_rise = !gate_prev_r && gate_now;
   wire gate_fall = gate_prev_r && !gate_now;
   // active edge: leading edge of the pulse, or the chosen period edge
   wire act_go = cfg_r.gate_low ? gate_fall : gate_rise;
   wire act_end = cfg_r.gate_low ? gate_rise : gate_fall;

   // single semi-period is the pulse width engine
   wire gpm_mode_t eff_mode = (cfg_r.mode == MODE_SEMI && !cfg_r.buffered) ? MODE_PW : cfg_r.mode;
   wire any_edge = gate_rise || gate_fall;
   wire start_ev = (eff_mode == MODE_SEMI) ? any_edge : act_go;
   wire end_ev = (eff_mode == MODE_PW) ? act_end : start_ev;

   ////////////////////////////////////////////////////////////////////////////
   // measurement state machine

   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r;
      latch = 1'b0;
      if (disarm_wr) begin
         state_nxt = ST_IDLE;
      end else if (arm_wr) begin
         state_nxt = ST_WAIT;
         count_nxt = COUNT_ZERO;
      end else begin
         case (state_r)
            ST_IDLE: begin
               state_nxt = ST_IDLE;
            end
            ST_WAIT: begin
               // interval in progress at arm time is skipped
               if (start_ev) begin
                  state_nxt = ST_COUNT;
                  count_nxt = COUNT_ZERO;
               end
            end
            ST_COUNT: begin
               if (end_ev) begin
                  latch = 1'b1;
                  count_nxt = COUNT_ZERO;
                  if (!cfg_r.buffered) begin
                     state_nxt = ST_DONE;
                  end else if (eff_mode == MODE_PW) begin
                     state_nxt = ST_WAIT;
                  end else begin
                     state_nxt = ST_COUNT;
                  end
               end else if (src_hit) begin
                  count_nxt = count_r + COUNT_ONE;
               end
            end
            ST_DONE: begin
               // edges ignored until software collects the value
               if (save_rd) begin
                  state_nxt = ST_IDLE;
               end
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r <= ST_IDLE;
         count_r <= COUNT_ZERO;
         save_r <= COUNT_ZERO;
         src_prev_r <= 1'b0;
         gate_prev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         src_prev_r <= src_seed;
         gate_prev_r <= gate_seed;
         if (latch) begin
            save_r <= count_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration and bus read

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_r <= CFG_RESET;
         pg_n_r <= COUNT_ZERO;
         pg_src_sel_r <= 2'h0;
         rd_data_r <= COUNT_ZERO;
      end else begin
         if (wr_ctrl) begin
            cfg_r <= cfg_wdata;
         end
         if (wr_pulse_n) begin
            pg_n_r <= bus_req.wdata;
         end
         if (wr_pulse_ctrl) begin
            pg_src_sel_r <= bus_req.wdata[PG_SRC_LSB +: 2];
         end
         rd_data_r <= bus_req.rd ? rd_mux : COUNT_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stream to host memory, one holding stage only

   wire push = latch && cfg_r.buffered;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stream_valid_r <= 1'b0;
         stream_data_r <= COUNT_ZERO;
         ovf_r <= 1'b0;
      end else begin
         if (push) begin
            stream_valid_r <= 1'b1;
            stream_data_r <= count_r;
         end else if (stream_ready) begin
            stream_valid_r <= 1'b0;
         end
         // set wins over a clear in the same cycle
         if (push && stream_valid_r && !stream_ready) begin
            ovf_r <= 1'b1;
         end else if (ovf_clr) begin
            ovf_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter zero one-shot pulse of n source periods

   wire pg_src = src_cand[pg_src_sel_r];
   wire pg_hit = !pg_prev_r && pg_src;
   wire [COUNT_W-1:0] pg_cnt_inc = pg_cnt_r + COUNT_ONE;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pg_busy_r <= 1'b0;
         pg_cnt_r <= COUNT_ZERO;
         pulse_out_r <= 1'b0;
         pg_prev_r <= 1'b0;
      end else begin
         pg_prev_r <= pg_src;
         if (pg_start) begin
            pg_busy_r <= 1'b1;
            pg_cnt_r <= COUNT_ZERO;
            pulse_out_r <= 1'b0;
         end else if (pg_busy_r && pg_hit) begin
            // pulse starts on a source edge so its width is whole periods
            if (!pulse_out_r) begin
               pulse_out_r <= 1'b1;
               pg_cnt_r <= COUNT_ZERO;
            end else if (pg_cnt_inc == pg_n_r) begin
               pulse_out_r <= 1'b0;
               pg_busy_r <= 1'b0;
            end else begin
               pg_cnt_r <= pg_cnt_inc;
            end
         end
      end
   end

   assign rd_data = rd_data_r;
   assign stream_data = stream_data_r;
   assign stream_valid = stream_valid_r;
   assign counter0_out = pulse_out_r;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   property p_no_latch_unarmed;
      (state_r == ST_IDLE && !arm_wr) |=> $stable(save_r) && !stream_valid_r || $past(stream_valid_r);
   endproperty
   a_no_latch_unarmed: assert property (p_no_latch_unarmed) else $error("latch while unarmed");

   property p_arm_clears;
      (arm_wr && !disarm_wr) |=> (count_r == COUNT_ZERO) && (state_r == ST_WAIT);
   endproperty
   a_arm_clears: assert property (p_arm_clears) else $error("arm did not clear count");

   sequence s_pw_end;
      state_r == ST_COUNT && eff_mode == MODE_PW && act_end && !ctl_wr;
   endsequence
   property p_pw_latch;
      s_pw_end |=> save_r == $past(count_r) && state_r != ST_COUNT;
   endproperty
   a_pw_latch: assert property (p_pw_latch) else $error("pulse width not latched");

   property p_stream;
      push |=> stream_valid_r && stream_data_r == $past(count_r);
   endproperty
   a_stream: assert property (p_stream) else $error("latched value not streamed");

   property p_single_hold;
      (state_r == ST_DONE && !save_rd && !ctl_wr) |=> state_r == ST_DONE && $stable(save_r);
   endproperty
   a_single_hold: assert property (p_single_hold) else $error("single result not held");

   property p_period_cont;
      (state_r == ST_COUNT && cfg_r.buffered && cfg_r.mode == MODE_PERIOD && act_go && !ctl_wr)
         |=> state_r == ST_COUNT && count_r == COUNT_ZERO;
   endproperty
   a_period_cont: assert property (p_period_cont) else $error("period counting stopped");

   property p_wait_start;
      (state_r == ST_WAIT && !start_ev && !ctl_wr) |=> state_r == ST_WAIT && !$rose(stream_valid_r);
   endproperty
   a_wait_start: assert property (p_wait_start) else $error("counted before first edge");

   property p_semi_latch;
      (state_r == ST_COUNT && eff_mode == MODE_SEMI && any_edge && !ctl_wr) |=> save_r == $past(count_r);
   endproperty
   a_semi_latch: assert property (p_semi_latch) else $error("semi-period edge missed");

   property p_src_count;
      (state_r == ST_COUNT && src_hit && !end_ev && !ctl_wr) |=> count_r == $past(count_r) + COUNT_ONE;
   endproperty
   a_src_count: assert property (p_src_count) else $error("source edge not counted");

   property p_overflow;
      (push && stream_valid_r && !stream_ready) |=> ovf_r ##1 (ovf_r || $past(ovf_clr));
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow not flagged");

   property p_pulse_len;
      pulse_out_r |-> pg_busy_r && pg_cnt_r < pg_n_r;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse longer than n");

endmodule

`default_nettype wire

// ---- test/gpm_far_side.sv ----
// far side model: source pulse maker and host memory sink
// assumes ref_clk from the bench; sink pace set by pace
`timescale 1ns/1ns
`default_nettype none

module gpm_far_side
   import gpm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic [1:0] pace,
   input wire logic [COUNT_W-1:0] stream_data,
   input wire logic stream_valid,
   output logic stream_ready,
   output logic src
);
   logic [COUNT_W-1:0] got[$];
   logic ph;

   initial begin
      src = 1'b0;
      ph = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pace 0 prompt, 1 every other cycle, 2 stalled
   assign stream_ready = (pace == 2'h0) || (pace == 2'h1 && ph);

   always @(posedge ref_clk) begin
      ph <= ~ph;
      if (stream_valid && stream_ready) begin
         got.push_back(stream_data);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // n pulses of g cycles high, g low; idles low, zero pulses allowed on purpose
   task automatic burst(input int n, input int g);
      repeat (n) begin
         src <= 1'b1;
         repeat (g) @(posedge ref_clk);
         src <= 1'b0;
         repeat (g) @(posedge ref_clk);
      end
   endtask
endmodule

`default_nettype wire

// ---- test/test_gpm_counter.sv ----
// bench for the gate period measure counter: random runs of every mode
// assumes gpm_pkg, the design and the far side model gpm_far_side
`timescale 1ns/1ns
`default_nettype none

module test_gpm_counter
   import gpm_pkg::*;
;
   logic ref_clk, reset, stream_valid, stream_ready, counter0_out, src, gate, free_clk;
   logic fast_tb, slow_tb;
   logic [3:0] eft;
   logic [1:0] pace, pick, gsel;
   logic [COUNT_W-1:0] rd_data, stream_data;
   gpm_bus_req_t bus_req;
   int seed = 65621;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;

   // unselected candidates show 0 or a running clock, so a wrong pick shows
   assign fast_tb = (pick == 2'h0) & src;
   assign slow_tb = (pick == 2'h1) ? src : free_clk;
   assign eft = {(gsel == 2'h1) ? gate : free_clk, (gsel == 2'h0) ? gate : free_clk,
      (pick == 2'h3) & src, (pick == 2'h2) & src};

   gpm_counter dut (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
      .fast_internal_timebase(fast_tb), .slow_timebase(slow_tb), .external_function_terminal(eft),
      .stream_data(stream_data), .stream_valid(stream_valid), .stream_ready(stream_ready),
      .counter0_out(counter0_out));

   gpm_far_side far (.ref_clk(ref_clk), .pace(pace), .stream_data(stream_data),
      .stream_valid(stream_valid), .stream_ready(stream_ready), .src(src));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      free_clk <= ~free_clk;
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [COUNT_W-1:0] seen, input logic [COUNT_W-1:0] expv);
      n_tests++;
      if (seen !== expv) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
      end
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // strobes drop, then one edge passes before the next request
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [COUNT_W-1:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [COUNT_W-1:0] v);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      @(posedge ref_clk);
      v = rd_data;
   endtask

   function automatic logic pw_like(input gpm_cfg_t f);
      return f.mode == MODE_PW || (f.mode == MODE_SEMI && !f.buffered);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // toggles gate h times with random source bursts; expectation built alongside
   task automatic meas(input int mode, input logic bf, input int h, input logic [1:0] p);
      gpm_cfg_t cfg;
      logic lvl, st, dn, pwl, bnd, lat, sta;
      int c, acc;
      logic [COUNT_W-1:0] v;
      logic [COUNT_W-1:0] eq[$];
      cfg = '{gate_sel: {1'b0, 1'($random(seed))}, src_sel: 2'($random(seed)),
         src_fall: 1'($random(seed)), gate_low: 1'($random(seed)), buffered: bf,
         mode: gpm_mode_t'(mode[1:0])};
      gsel <= cfg.gate_sel;
      pick <= cfg.src_sel;
      pace <= p;
      lvl = cfg.gate_low;
      gate <= lvl;
      st = 1'b0;
      dn = 1'b0;
      acc = 0;
      pwl = pw_like(cfg);
      repeat (2) @(posedge ref_clk);
      wr(ADDR_CTRL, {19'h0, cfg, 4'h1});
      rd(ADDR_CTRL, v);
      check(v, {19'h0, cfg, 4'h0});
      rd(ADDR_COUNT, v);
      check(v, 32'h0);
      for (int t = 0; t <= h; t++) begin
         c = {$random(seed)} % 4;
         far.burst(c, 1 + {$random(seed)} % 2);
         if (st && !dn && (!pwl || lvl != cfg.gate_low)) acc += c;
         if (t < h) begin
            lvl = ~lvl;
            gate <= lvl;
            repeat (4) @(posedge ref_clk);
            bnd = cfg.mode == MODE_SEMI || lvl != cfg.gate_low;
            lat = pwl ? lvl == cfg.gate_low : bnd;
            sta = pwl ? lvl != cfg.gate_low : bnd;
            if (lat && st && !dn) begin
               eq.push_back(COUNT_W'(acc));
               dn = !bf;
            end
            if (sta) begin
               st = 1'b1;
               acc = 0;
            end
         end
      end
      repeat (8) @(posedge ref_clk);
      if (bf) begin
         if (p == 2'h2) begin
            rd(ADDR_STATUS, v);
            check(v[ST_OVF_BIT], 1'b1);
            wr(ADDR_STATUS, 32'h4);
            rd(ADDR_STATUS, v);
            check(v[ST_OVF_BIT], 1'b0);
         end else begin
            check(32'(far.got.size()), 32'(eq.size()));
            while (eq.size() > 0 && far.got.size() > 0) begin
               check(far.got.pop_front(), eq.pop_front());
            end
         end
         wr(ADDR_CTRL, 32'h2);
      end else begin
         rd(ADDR_STATUS, v);
         check(v[1:0], 2'h3);
         rd(ADDR_SAVE, v);
         check(v, eq[0]);
      end
      pace <= 2'h0;
      repeat (6) @(posedge ref_clk);
      far.got.delete();
      rd(ADDR_STATUS, v);
      check(v[2:0], 3'h0);
   endtask

   // pulse of n source periods gates a single pulse width on the free clock
   task automatic chain(input int n, input int g);
      int hi;
      logic [COUNT_W-1:0] v;
      hi = 0;
      gsel <= 2'h2;
      pick <= 2'h2;
      wr(ADDR_CTRL, {19'h0, 2'h3, 2'h1, 5'h0, 4'h1});
      wr(ADDR_PULSE_N, n);
      wr(ADDR_PULSE_CTRL, 32'h5);
      rd(ADDR_PULSE_CTRL, v);
      check(v, 32'h5);
      fork
         far.burst(n + 2, g);
         repeat ((n + 2) * 2 * g + 4) begin
            @(posedge ref_clk);
            hi += counter0_out;
         end
      join
      check(hi, n * 2 * g);
      rd(ADDR_SAVE, v);
      // phase against the free clock allows one count either way
      check(32'(v + 1 - n * g <= 2), 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [COUNT_W-1:0] v;
      reset = 1'b1;
      bus_req = '0;
      gate = 1'b0;
      free_clk = 1'b0;
      pace = 2'h0;
      pick = 2'h0;
      gsel = 2'h0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      repeat (3) begin
         gate <= ~gate;
         far.burst(2, 1);
      end
      check(32'(far.got.size()), 32'h0);
      rd(ADDR_SAVE, v);
      check(v, 32'h0);
      rd(ADDR_STATUS, v);
      check(v, 32'h0);
      rd(8'hFC, v);
      check(v, 32'h0);
      for (int i = 0; i < 12; i++) begin
         meas(i % 3, 1'((i / 3) % 2), 4 + {$random(seed)} % 4, (i >= 6) ? 2'h1 : 2'h0);
      end
      meas(2, 1'b1, 5, 2'h2);
      chain(3, 2);
      chain(1, 3);
      summarize();
   end
endmodule

`default_nettype wire
